// *** logic/gsaux_ctrl.sv ***
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Idle relay held for run-idle seconds once engine runs.
// - Idle relay held for stop-idle seconds before stop.
// - Low voltage, frequency, speed checks masked while idle.
// - Checks return only after holdoff seconds past idle.
// - Gas solenoid opens after its delay while cranking, if assigned.
// - Crank released when first phase voltage reaches cut level.
// - Crank released when frequency reaches cut level.
// - Crank released when engine speed reaches cut level.
// - Crank released when charge voltage reaches cut level.
// - Charge-input bit enables the charge-voltage crank cut.
// - Oil bit: switch open or pressure over limit cuts crank.
// - Oil crank cut waits its own delay after condition.
// - Zero tank capacity means no fuel quantity shown.
// - Theft and refuel notes on change above hourly threshold.
// - Cooler relay on above cooler-on temperature.
// - Cooler turns off below cooler-off temperature, hysteresis.
// - Cooler held for fan overrun seconds after dropping.
// - Heater on below heater-on, off above heater-off.
// - Canopy and ambient fans use their own on/off levels.
// - Service request when engine hours reach set count.
// - Service request when months reach set count.
// - Alarm level selects action of a due service.
module gsaux_ctrl #(
	parameter int TICK_CYCLES = gsaux_pkg::TICK_CYCLES,
	parameter int HOUR_TICKS  = gsaux_pkg::HOUR_S
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Register bus write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Register bus read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Engine sequence
	input  wire logic        engine_running,
	input  wire logic        stop_request,
	input  wire logic        crank_request,
	input  wire logic        oil_switch_open,
	input  wire logic        month_tick,
	// Measurements
	input  wire logic [15:0] first_phase_volt,
	input  wire logic [6:0]  gen_freq,
	input  wire logic [15:0] engine_rpm,
	input  wire logic [5:0]  charge_volt,
	input  wire logic [15:0] oil_pressure,
	input  wire logic [7:0]  coolant_temp,
	input  wire logic [7:0]  canopy_temp,
	input  wire logic [7:0]  ambient_temp,
	input  wire logic [6:0]  fuel_level,
	// Relays and indications
	output logic             idle_relay,
	output logic             low_checks_enable,
	output logic             stop_permit,
	output logic             crank_relay,
	output logic             gas_solenoid,
	output logic             cooler_relay,
	output logic             heater_relay,
	output logic             canopy_fan_relay,
	output logic             ambient_fan_relay,
	output logic             service_request,
	output logic [1:0]       service_action,
	output logic             fuel_quantity_valid,
	output logic [15:0]      fuel_quantity,
	output logic             fuel_theft_note,
	output logic             refuel_note
);
	if (TICK_CYCLES < 2 || HOUR_TICKS < 2 || HOUR_TICKS > 4095) begin : g_bad
		$error("gsaux_ctrl: timing parameter out of range");
	end

	localparam int TW = $clog2(TICK_CYCLES);

	function automatic logic hyst(input logic cur, input logic on_c,
		input logic off_c);
		return on_c ? 1'b1 : (off_c ? 1'b0 : cur);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ************************************************************
	// Register bus slave
	// ************************************************************
	logic [31:0] cfg [0:gsaux_pkg::N_CFG-1];
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_held;
	logic        w_held;
	logic        ar_busy;
	logic        wr_do;
	logic        next_aw_held;
	logic        next_w_held;
	logic        next_ar_busy;
	logic [31:0] status;
	logic [1:0]  events;
	logic        svc_clr;
	logic        ev_clr_theft;
	logic        ev_clr_fill;
	logic [3:0]  wr_idx;
	logic [3:0]  rd_idx;

	assign wr_do        = aw_held && w_held && !bvalid;
	assign next_aw_held = wr_do ? 1'b0 : (aw_held || (awvalid && awready));
	assign next_w_held  = wr_do ? 1'b0 : (w_held || (wvalid && wready));
	assign next_ar_busy = (rvalid && rready) ? 1'b0
		: (ar_busy || (arvalid && arready));
	assign wr_idx       = aw_addr[7:6] != 2'h0 ? 4'hf : aw_addr[5:2];
	assign rd_idx       = araddr[7:6] != 2'h0 ? 4'hf : araddr[5:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			awready <= !next_aw_held;
			wready  <= !next_w_held;
			if (awvalid && awready) begin
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= gsaux_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid <= 1'b1;
			bresp  <= (aw_addr[1:0] == 2'h0 && (int'(wr_idx) <
				gsaux_pkg::N_CFG || aw_addr == gsaux_pkg::A_EVENTS))
				? gsaux_pkg::RESP_OKAY : gsaux_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// The service clear bit is an action: it pulses for one cycle and reads back as 0 after that.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg[0] <= gsaux_pkg::R_CTRL;
			cfg[1] <= gsaux_pkg::R_IDLE;
			cfg[2] <= gsaux_pkg::R_CRANK;
			cfg[3] <= gsaux_pkg::R_CUT_VR;
			cfg[4] <= gsaux_pkg::R_CUT_MSC;
			cfg[5] <= gsaux_pkg::R_COOLER;
			cfg[6] <= gsaux_pkg::R_HEATER;
			cfg[7] <= gsaux_pkg::R_FANS;
			cfg[8] <= gsaux_pkg::R_SERVICE;
			cfg[9] <= gsaux_pkg::R_FUEL;
		end else begin
			cfg[0][gsaux_pkg::F_SVC_CLR] <= 1'b0;
			if (wr_do && aw_addr[1:0] == 2'h0
				&& int'(wr_idx) < gsaux_pkg::N_CFG) begin
				cfg[wr_idx] <= merge(cfg[wr_idx], w_data, w_strb);
			end
		end
	end

	assign svc_clr      = cfg[0][gsaux_pkg::F_SVC_CLR];
	assign ev_clr_theft = wr_do && aw_addr == gsaux_pkg::A_EVENTS
		&& w_strb[0] && w_data[gsaux_pkg::F_EV_THEFT];
	assign ev_clr_fill  = wr_do && aw_addr == gsaux_pkg::A_EVENTS
		&& w_strb[0] && w_data[gsaux_pkg::F_EV_FILL];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_busy <= 1'b0;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= gsaux_pkg::RESP_OKAY;
		end else begin
			ar_busy <= next_ar_busy;
			arready <= !next_ar_busy;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= gsaux_pkg::RESP_OKAY;
				if (araddr[1:0] != 2'h0) begin
					rdata <= 32'h0000_0000;
					rresp <= gsaux_pkg::RESP_SLVERR;
				end else if (int'(rd_idx) < gsaux_pkg::N_CFG) begin
					rdata <= cfg[rd_idx];
				end else if (araddr == gsaux_pkg::A_STATUS) begin
					rdata <= status;
				end else if (araddr == gsaux_pkg::A_EVENTS) begin
					rdata <= {30'h0000_0000, events};
				end else begin
					rdata <= 32'h0000_0000;
					rresp <= gsaux_pkg::RESP_SLVERR;
				end
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Pin synchronisers and time base
	// ************************************************************
	logic [1:0]    pin_s1;
	logic [1:0]    pin_s2;
	logic [1:0]    pin_s3;
	logic [1:0]    pin_lvl;
	logic          month_seen;
	logic [TW-1:0] tick_cnt;
	logic          sec_tick;
	logic [11:0]   hour_secs;
	logic [11:0]   run_secs;
	logic          hour_tick;

	// A pin level is taken only once two stages agree, which rejects
	// a sample caught in the middle of an edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1     <= 2'h0;
			pin_s2     <= 2'h0;
			pin_s3     <= 2'h0;
			pin_lvl    <= 2'h0;
			month_seen <= 1'b0;
		end else begin
			pin_s1     <= {month_tick, oil_switch_open};
			pin_s2     <= pin_s1;
			pin_s3     <= pin_s2;
			pin_lvl    <= (pin_s2 ~^ pin_s3) & pin_s3
				| (pin_s2 ^ pin_s3) & pin_lvl;
			month_seen <= pin_lvl[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= '0;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= (int'(tick_cnt) == TICK_CYCLES - 1);
			tick_cnt <= (int'(tick_cnt) == TICK_CYCLES - 1)
				? '0 : tick_cnt + 1'b1;
		end
	end

	// ************************************************************
	// Idle control and check holdoff
	// ************************************************************
	gsaux_pkg::gsaux_eng_t eng;
	gsaux_pkg::gsaux_eng_t next_eng;
	logic run_idle_done;
	logic stop_idle_done;

	always_comb begin
		next_eng = eng;
		case (eng)
		gsaux_pkg::ES_STOPPED: begin
			if (engine_running) begin
				next_eng = gsaux_pkg::ES_RUN_IDLE;
			end
		end
		gsaux_pkg::ES_RUN_IDLE: begin
			if (stop_request) begin
				next_eng = gsaux_pkg::ES_STOP_IDLE;
			end else if (run_idle_done) begin
				next_eng = gsaux_pkg::ES_RUN;
			end
		end
		gsaux_pkg::ES_RUN: begin
			if (stop_request) begin
				next_eng = gsaux_pkg::ES_STOP_IDLE;
			end
		end
		gsaux_pkg::ES_STOP_IDLE: begin
			if (stop_idle_done) begin
				next_eng = gsaux_pkg::ES_STOP_OK;
			end
		end
		gsaux_pkg::ES_STOP_OK: begin
		end
		default: begin
			next_eng = gsaux_pkg::ES_STOPPED;
		end
		endcase
		if (!engine_running) begin
			next_eng = gsaux_pkg::ES_STOPPED;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eng         <= gsaux_pkg::ES_STOPPED;
			idle_relay  <= 1'b0;
			stop_permit <= 1'b0;
		end else begin
			eng         <= next_eng;
			idle_relay  <= next_eng == gsaux_pkg::ES_RUN_IDLE
				|| next_eng == gsaux_pkg::ES_STOP_IDLE;
			stop_permit <= next_eng == gsaux_pkg::ES_STOP_OK;
		end
	end

	gsaux_sec_timer #(.W(8)) u_run_idle (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sec_tick (sec_tick),
		.arm      (eng == gsaux_pkg::ES_RUN_IDLE),
		.limit    (cfg[1][gsaux_pkg::F_LO_BYTE +: 8]),
		.done     (run_idle_done)
	);

	gsaux_sec_timer #(.W(8)) u_stop_idle (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sec_tick (sec_tick),
		.arm      (eng == gsaux_pkg::ES_STOP_IDLE),
		.limit    (cfg[1][gsaux_pkg::F_HI_BYTE +: 8]),
		.done     (stop_idle_done)
	);

	// Arm looks at the next state, so checks drop on the edge idle starts.
	gsaux_sec_timer #(.W(5)) u_holdoff (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sec_tick (sec_tick),
		.arm      (engine_running && next_eng != gsaux_pkg::ES_RUN_IDLE
			&& next_eng != gsaux_pkg::ES_STOP_IDLE),
		.limit    (cfg[1][gsaux_pkg::F_TOP_BYTE +: 5]),
		.done     (low_checks_enable)
	);

	// ************************************************************
	// Cranking
	// ************************************************************
	logic oil_cond;
	logic oil_done;
	logic cut_now;
	logic cut_held;

	assign oil_cond = cfg[0][gsaux_pkg::F_OIL_EN] && (pin_lvl[0]
		|| oil_pressure > cfg[4][gsaux_pkg::F_HI_HALF +: 16]);

	gsaux_sec_timer #(.W(8)) u_gas (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sec_tick (sec_tick),
		.arm      (crank_request && cfg[0][gsaux_pkg::F_GAS_EN]),
		.limit    (cfg[2][gsaux_pkg::F_LO_BYTE +: 8]),
		.done     (gas_solenoid)
	);

	gsaux_sec_timer #(.W(5)) u_oil (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sec_tick (sec_tick),
		.arm      (crank_request && oil_cond),
		.limit    (cfg[2][gsaux_pkg::F_HI_BYTE +: 5]),
		.done     (oil_done)
	);

	assign cut_now =
		first_phase_volt >= cfg[3][gsaux_pkg::F_LO_HALF +: 16]
		|| gen_freq >= cfg[4][gsaux_pkg::F_LO_BYTE +: 7]
		|| engine_rpm >= cfg[3][gsaux_pkg::F_HI_HALF +: 16]
		|| (cfg[0][gsaux_pkg::F_CHG_EN]
		&& charge_volt >= cfg[4][gsaux_pkg::F_HI_BYTE +: 6])
		|| oil_done;

	// Once cut, the crank stays released until the request is withdrawn,
	// so a dip in speed cannot re-engage the starter on a turning engine.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cut_held    <= 1'b0;
			crank_relay <= 1'b0;
		end else begin
			cut_held    <= crank_request && (cut_held || cut_now);
			crank_relay <= crank_request && !cut_held && !cut_now;
		end
	end

	// ************************************************************
	// Temperature relays
	// ************************************************************
	logic cool_hot;
	logic overrun_done;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cool_hot          <= 1'b0;
			cooler_relay      <= 1'b0;
			heater_relay      <= 1'b0;
			canopy_fan_relay  <= 1'b0;
			ambient_fan_relay <= 1'b0;
		end else begin
			cool_hot <= hyst(cool_hot,
				coolant_temp > cfg[5][gsaux_pkg::F_LO_BYTE +: 8],
				coolant_temp < cfg[5][gsaux_pkg::F_HI_BYTE +: 8]);
			cooler_relay <= cool_hot
				|| (cooler_relay && !overrun_done);
			heater_relay <= hyst(heater_relay,
				coolant_temp < cfg[6][gsaux_pkg::F_LO_BYTE +: 8],
				coolant_temp > cfg[6][gsaux_pkg::F_HI_BYTE +: 8]);
			canopy_fan_relay <= hyst(canopy_fan_relay,
				canopy_temp > cfg[7][gsaux_pkg::F_LO_BYTE +: 8],
				canopy_temp < cfg[7][gsaux_pkg::F_HI_BYTE +: 8]);
			ambient_fan_relay <= hyst(ambient_fan_relay,
				ambient_temp > cfg[7][gsaux_pkg::F_TOP_BYTE +: 8],
				ambient_temp < cfg[7][gsaux_pkg::F_TOP_SEAT +: 8]);
		end
	end

	gsaux_sec_timer #(.W(8)) u_overrun (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sec_tick (sec_tick),
		.arm      (cooler_relay && !cool_hot),
		.limit    (cfg[5][gsaux_pkg::F_TOP_BYTE +: 8]),
		.done     (overrun_done)
	);

	// ************************************************************
	// Service counters
	// ************************************************************
	logic [12:0] eng_hours;
	logic [4:0]  months;
	logic        svc_due;
	logic [12:0] svc_hours;
	logic [4:0]  svc_months;

	assign svc_hours  = cfg[8][gsaux_pkg::F_LO_HALF +: 13];
	assign svc_months = cfg[8][gsaux_pkg::F_TOP_BYTE +: 5];
	assign svc_due    = (svc_hours != 13'h0000
		&& eng_hours >= svc_hours)
		|| (svc_months != 5'h00 && months >= svc_months);

	always_ff @(posedge aclk) begin
		if (!aresetn || svc_clr) begin
			run_secs  <= 12'h000;
			eng_hours <= 13'h0000;
			months    <= 5'h00;
		end else begin
			if (sec_tick && engine_running) begin
				run_secs <= (int'(run_secs) == HOUR_TICKS - 1)
					? 12'h000 : run_secs + 1'b1;
				if (int'(run_secs) == HOUR_TICKS - 1
					&& eng_hours != 13'h1fff) begin
					eng_hours <= eng_hours + 1'b1;
				end
			end
			if (pin_lvl[1] && !month_seen && months != 5'h1f) begin
				months <= months + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			service_request <= 1'b0;
			service_action  <= 2'h0;
		end else begin
			service_request <= svc_due;
			service_action  <= svc_due
				? cfg[8][gsaux_pkg::F_TOP_SEAT +: 2] : 2'h0;
		end
	end

	// ************************************************************
	// Fuel
	// ************************************************************
	logic [6:0]  fuel_prev;
	logic [6:0]  fuel_thr;
	logic [15:0] tank_cap;
	logic [22:0] fuel_prod;
	logic        theft_now;
	logic        fill_now;

	assign tank_cap  = cfg[9][gsaux_pkg::F_LO_HALF +: 16];
	assign fuel_thr  = cfg[9][gsaux_pkg::F_TOP_BYTE +: 7];
	assign fuel_prod = tank_cap * fuel_level;
	assign hour_tick = sec_tick && int'(hour_secs) == HOUR_TICKS - 1;
	assign theft_now = hour_tick && fuel_thr != 7'h00
		&& fuel_prev > fuel_level && fuel_prev - fuel_level > fuel_thr;
	assign fill_now  = hour_tick && fuel_thr != 7'h00
		&& fuel_level > fuel_prev && fuel_level - fuel_prev > fuel_thr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hour_secs           <= 12'h000;
			fuel_prev           <= 7'h00;
			fuel_quantity_valid <= 1'b0;
			fuel_quantity       <= 16'h0000;
			fuel_theft_note     <= 1'b0;
			refuel_note         <= 1'b0;
		end else begin
			if (sec_tick) begin
				hour_secs <= hour_tick ? 12'h000 : hour_secs + 1'b1;
			end
			if (hour_tick) begin
				fuel_prev <= fuel_level;
			end
			fuel_quantity_valid <= tank_cap != 16'h0000;
			fuel_quantity <= (tank_cap != 16'h0000)
				? 16'(fuel_prod / 23'(gsaux_pkg::PERCENT_FULL)) : 16'h0000;
			fuel_theft_note <= theft_now;
			refuel_note     <= fill_now;
		end
	end

	// A new event in the clearing cycle wins over the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			events <= 2'h0;
		end else begin
			events[gsaux_pkg::F_EV_THEFT] <= theft_now
				|| (events[gsaux_pkg::F_EV_THEFT] && !ev_clr_theft);
			events[gsaux_pkg::F_EV_FILL] <= fill_now
				|| (events[gsaux_pkg::F_EV_FILL] && !ev_clr_fill);
		end
	end

	assign status = {3'h0, eng_hours, months, 2'h0, service_request,
		ambient_fan_relay, canopy_fan_relay, heater_relay, cooler_relay,
		gas_solenoid, crank_relay, low_checks_enable, idle_relay};
endmodule // gsaux_ctrl
`default_nettype wire

// *** logic/gsaux_pkg.sv ***
package gsaux_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS  = 25;
	localparam int TICK_PERIOD_MS = 1000;
	localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int HOUR_S         = 3600;
	localparam int PERCENT_FULL   = 100;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam int N_CFG  = 10;
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_IDLE    = 8'h04;
	localparam logic [7:0] A_CRANK   = 8'h08;
	localparam logic [7:0] A_CUT_VR  = 8'h0c;
	localparam logic [7:0] A_CUT_MSC = 8'h10;
	localparam logic [7:0] A_COOLER  = 8'h14;
	localparam logic [7:0] A_HEATER  = 8'h18;
	localparam logic [7:0] A_FANS    = 8'h1c;
	localparam logic [7:0] A_SERVICE = 8'h20;
	localparam logic [7:0] A_FUEL    = 8'h24;
	localparam logic [7:0] A_STATUS  = 8'h28;
	localparam logic [7:0] A_EVENTS  = 8'h2c;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] R_CTRL    = 32'h0000_0000;
	localparam logic [31:0] R_IDLE    = 32'h000a_0000;
	localparam logic [31:0] R_CRANK   = 32'h0000_0205;
	localparam logic [31:0] R_CUT_VR  = 32'h01f4_0064;
	localparam logic [31:0] R_CUT_MSC = 32'h0064_060a;
	localparam logic [31:0] R_COOLER  = 32'h0000_505a;
	localparam logic [31:0] R_HEATER  = 32'h0000_3c32;
	localparam logic [31:0] R_FANS    = 32'h505a_505a;
	localparam logic [31:0] R_SERVICE = 32'h0306_00fa;
	localparam logic [31:0] R_FUEL    = 32'h0000_0000;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int F_CHG_EN   = 0;
	localparam int F_OIL_EN   = 1;
	localparam int F_GAS_EN   = 2;
	localparam int F_SVC_CLR  = 3;
	localparam int F_LO_BYTE  = 0;
	localparam int F_HI_BYTE  = 8;
	localparam int F_TOP_BYTE = 16;
	localparam int F_TOP_SEAT = 24;
	localparam int F_LO_HALF  = 0;
	localparam int F_HI_HALF  = 16;
	localparam int F_ST_HRS   = 16;
	localparam int F_ST_MON   = 11;
	localparam int F_EV_THEFT = 0;
	localparam int F_EV_FILL  = 1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ES_STOPPED, ES_RUN_IDLE, ES_RUN, ES_STOP_IDLE, ES_STOP_OK
	} gsaux_eng_t;
endpackage

// *** logic/gsaux_sec_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsaux_sec_timer #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Timing
	input  wire logic         sec_tick,
	input  wire logic         arm,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	logic [W-1:0] count;

	if (W < 1 || W > 16) begin : g_bad_w
		$error("gsaux_sec_timer: width out of range");
	end

	// Dropping arm restarts the count, so each new cause starts at zero.
	always_ff @(posedge aclk) begin
		if (!aresetn || !arm) begin
			count <= '0;
			done  <= 1'b0;
		end else if (count >= limit) begin
			done <= 1'b1;
		end else if (sec_tick) begin
			count <= count + 1'b1;
		end
	end
endmodule // gsaux_sec_timer
`default_nettype wire

// *** tb/gsaux_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsaux_ctrl_tb;
	// ***
	// Bench
	// ***
	logic       aclk = 1'h0, aresetn = 1'h0, spin = 1'h0;
	logic       awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic       arvalid = 1'h0, rready = 1'h0, month_tick = 1'h0;
	logic       engine_running = 1'h0, stop_request = 1'h0;
	logic       crank_request = 1'h0, oil_switch_open = 1'h0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, coolant_temp = 8'h46;
	logic [7:0] canopy_temp = 8'h46, ambient_temp = 8'h46;
	logic [31:0] wdata = 32'h0, rdata;
	logic [15:0] oil_pressure = 16'h0, engine_rpm, first_phase_volt;
	logic [15:0] fuel_quantity;
	logic [6:0] fuel_level = 7'h32, gen_freq;
	logic [5:0] charge_volt;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, service_action;
	logic       awready, wready, bvalid, arready, rvalid, idle_relay;
	logic       low_checks_enable, stop_permit, crank_relay, gas_solenoid;
	logic       cooler_relay, heater_relay, canopy_fan_relay;
	logic       ambient_fan_relay, service_request, fuel_quantity_valid;
	logic       fuel_theft_note, refuel_note;
	int         err_total = 0, checks = 0, cyc = 0, n, m;
	logic [7:0] tt [6] = '{8'h5b, 8'h55, 8'h4f, 8'h31, 8'h37, 8'h3d};
	logic [3:0] tr [6] = '{4'hb, 4'hb, 4'h0, 4'h4, 4'h4, 4'h0};
	wire logic [6:0] mon = {crank_relay, refuel_note, service_request,
		stop_permit, gas_solenoid, low_checks_enable, idle_relay};
	gsaux_ctrl #(.TICK_CYCLES(8), .HOUR_TICKS(3)) uut (.*);
	gsaux_eng_model eng (.*);
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wt(input int i, input logic v, output int c);
		c = 0;
		while (mon[i] !== v && c < 300) begin
			@(posedge aclk);
			c++;
		end
	endtask
	// Read data is compared only where OKAY is due; error data is undefined.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (arready) arvalid <= 1'h0;
		end while (bvalid !== 1'h1 && rvalid !== 1'h1);
		bready <= 1'h0;
		rready <= 1'h0;
		chk("resp", {30'h0, er}, {30'h0, w ? bresp : rresp});
		if (!w && er == 2'h0) chk("rdata", d, rdata);
	endtask
	task automatic crank(input logic [31:0] c, input int lo, input logic g);
		bus(1'h1, gsaux_pkg::A_CTRL, c, 2'h0);
		crank_request <= 1'h1;
		spin <= 1'h1;
		wt(6, 1'h1, n);
		wt(6, 1'h0, m);
		chk("cut", 1, {31'h0, engine_rpm >= lo && engine_rpm < lo + 75});
		spin <= 1'h0;
		m = m + n;
		if (g) begin
			wt(2, 1'h1, n);
			chk("gas", 1, {31'h0, m + n >= 33 && m + n <= 46});
		end
		crank_request <= 1'h0;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		bus(1'h0, gsaux_pkg::A_IDLE, gsaux_pkg::R_IDLE, 2'h0);
		bus(1'h0, gsaux_pkg::A_CRANK, gsaux_pkg::R_CRANK, 2'h0);
		bus(1'h0, gsaux_pkg::A_SERVICE, gsaux_pkg::R_SERVICE, 2'h0);
		bus(1'h1, gsaux_pkg::A_STATUS, 32'h1, 2'h2);
		bus(1'h0, 8'h30, 32'h0, 2'h2);
		crank(32'h4, 500, 1'h1);
		bus(1'h1, gsaux_pkg::A_CUT_VR, 32'hffff_ffff, 2'h0);
		crank(32'h1, 480, 1'h0);
		crank(32'h0, 600, 1'h0);
		bus(1'h1, gsaux_pkg::A_IDLE, 32'h0001_0102, 2'h0);
		engine_running <= 1'h1;
		wt(0, 1'h1, n);
		wt(0, 1'h0, n);
		chk("run_idle", 1, {31'h0, n >= 8 && n <= 19});
		wt(1, 1'h1, n);
		chk("holdoff", 1, {31'h0, n >= 1 && n <= 11});
		stop_request <= 1'h1;
		wt(0, 1'h1, n);
		wt(0, 1'h0, n);
		chk("stop_idle", 1, {31'h0, n >= 1 && n <= 11});
		wt(3, 1'h1, n);
		chk("permit", 1, {31'h0, n <= 3});
		stop_request <= 1'h0;
		engine_running <= 1'h0;
		for (int i = 0; i < 6; i++) begin
			coolant_temp <= tt[i];
			canopy_temp <= tt[i];
			ambient_temp <= tt[i];
			repeat (5) @(posedge aclk);
			chk("relays", {28'h0, tr[i]}, {28'h0, cooler_relay, heater_relay,
				canopy_fan_relay, ambient_fan_relay});
		end
		for (int i = 0; i < 6; i++) begin
			chk("svc_early", 0, {31'h0, service_request});
			month_tick <= 1'h1;
			repeat (4) @(posedge aclk);
			month_tick <= 1'h0;
			repeat (4) @(posedge aclk);
		end
		repeat (4) @(posedge aclk);
		chk("svc", 7, {29'h0, service_request, service_action});
		bus(1'h1, gsaux_pkg::A_CTRL, 32'h8, 2'h0);
		repeat (3) @(posedge aclk);
		chk("svc_clr", 0, {31'h0, service_request});
		chk("fuel_off", 0, {31'h0, fuel_quantity_valid});
		bus(1'h1, gsaux_pkg::A_FUEL, 32'h0005_00c8, 2'h0);
		fuel_level <= 7'h50;
		wt(5, 1'h1, n);
		chk("refuel", 1, {31'h0, n < 60});
		chk("fuel", 32'h1_00a0, {15'h0, fuel_quantity_valid, fuel_quantity});
		stop_test();
	end
endmodule // gsaux_ctrl_tb
bind gsaux_ctrl gsaux_props u_props (.*);
`default_nettype wire

// *** tb/gsaux_eng_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***
// Engine model
// ***
module gsaux_eng_model (
	// Clock and reset
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// Command
	input  wire logic  spin,
	// Measurements
	output logic [15:0] engine_rpm,
	output logic [15:0] first_phase_volt,
	output logic [6:0]  gen_freq,
	output logic [5:0]  charge_volt
);
	// Speed falls to rest at once, so every crank starts from standstill.
	always_ff @(posedge aclk) begin
		engine_rpm <= (!aresetn || !spin) ? 16'h0 : engine_rpm + 16'h19;
	end
	assign first_phase_volt = engine_rpm / 16'h5;
	assign gen_freq = 7'(engine_rpm / 16'h3c);
	assign charge_volt = 6'(engine_rpm / 16'h50);
endmodule // gsaux_eng_model
`default_nettype wire

// *** tb/gsaux_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***
// Port checker
// ***
module gsaux_props (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Watched ports
	input wire logic       crank_request,
	input wire logic       crank_relay,
	input wire logic       gas_solenoid,
	input wire logic [6:0] gen_freq,
	input wire logic       idle_relay,
	input wire logic       low_checks_enable,
	input wire logic       stop_permit,
	input wire logic       fuel_theft_note,
	input wire logic       refuel_note,
	input wire logic       service_request,
	input wire logic [1:0] service_action
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_req; crank_relay |-> $past(crank_request); endproperty
	// The bench never moves the cut frequency off its reset value.
	property p_frq; crank_relay |-> $past(gen_freq) < 7'h0a; endproperty
	property p_gas; gas_solenoid |-> $past(crank_request); endproperty
	property p_mask; idle_relay |-> !low_checks_enable; endproperty
	property p_perm; stop_permit |-> !idle_relay; endproperty
	property p_pulse; refuel_note |=> !refuel_note; endproperty
	property p_excl; !(fuel_theft_note && refuel_note); endproperty
	property p_svc; service_action != 2'h0 |-> service_request; endproperty
	a_req: assert property (p_req) else $error("crank");
	a_frq: assert property (p_frq) else $error("freq cut");
	a_gas: assert property (p_gas) else $error("gas");
	a_mask: assert property (p_mask) else $error("mask");
	a_perm: assert property (p_perm) else $error("permit");
	a_pulse: assert property (p_pulse) else $error("note");
	a_excl: assert property (p_excl) else $error("notes");
	a_svc: assert property (p_svc) else $error("action");
	c_cut: cover property ($fell(crank_relay) && crank_request);
	c_idle: cover property ($rose(idle_relay));
	c_svc: cover property ($rose(service_request));
endmodule // gsaux_props
`default_nettype wire
